// ---- uerx_params.svh ----
// Constants for the USB endpoint receive control block
`ifndef UERX_PARAMS_SVH
`define UERX_PARAMS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define UERX_OFF_EP0       12'h000
`define UERX_OFF_EP1       12'h004
`define UERX_OFF_EP2       12'h008
`define UERX_OFF_IRQ_STAT  12'h00c
`define UERX_OFF_IRQ_CLR   12'h010
`define UERX_OFF_IRQ_EN    12'h014

// ---------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------
`define UERX_BIT_CTRL      7
`define UERX_BIT_TOG       6
`define UERX_STAT_HI       5
`define UERX_STAT_LO       4
`define UERX_EPN_HI        3
`define UERX_EPN_LO        0
`define UERX_EP0_RESET     8'h80
`define UERX_EPX_RESET     8'h00
`define UERX_NUM_EP        3
`define UERX_IRQ_W         4

`endif

// ---- uerx_pkg.sv ----
// Types for the USB endpoint receive control block
package uerx_pkg;

    typedef enum logic [1:0]
    {
        UERX_ST_DISABLED = 2'h0,
        UERX_ST_STALL    = 2'h1,
        UERX_ST_NAK      = 2'h2,
        UERX_ST_VALID    = 2'h3
    } uerx_stat_t;

    typedef enum logic [1:0]
    {
        UERX_HS_NONE  = 2'h0,
        UERX_HS_ACK   = 2'h1,
        UERX_HS_NAK   = 2'h2,
        UERX_HS_STALL = 2'h3
    } uerx_hs_t;

    typedef enum logic [1:0]
    {
        UERX_PID_OUT   = 2'h0,
        UERX_PID_SETUP = 2'h1
    } uerx_tok_t;

endpackage

// ---- uerx_epreg.sv ----
// One endpoint receive control register with hardware updates
`timescale 1ns/1ps
`default_nettype none
`include "uerx_params.svh"

module uerx_epreg
#(
    parameter bit IS_EP0 = 1'b0
)
(
    input  wire logic       MCLK_I,
    input  wire logic       ARST_N_I,
    input  wire logic       bus_rst_i,
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       setup_clr_i,
    input  wire logic       tog_flip_i,
    input  wire logic       force_nak_i,
    output logic      [7:0] reg_o
);
    import uerx_pkg::*;

    typedef struct packed
    {
        logic [7:0] value;
    } uerx_epreg_state_t;

    uerx_epreg_state_t state_ff;
    uerx_epreg_state_t nxt_state;

    localparam logic [7:0] RST_VAL = IS_EP0 ? `UERX_EP0_RESET
                                            : `UERX_EPX_RESET;

    always_comb
    begin
        nxt_state = state_ff;
        if (bus_rst_i)
        begin
            nxt_state.value = RST_VAL;
        end
        else
        begin
            if (wr_i)
            begin
                nxt_state.value = wdata_i;
            end
            // Hardware updates win over a same-cycle software write
            if (setup_clr_i)
            begin
                nxt_state.value[`UERX_BIT_TOG] = 1'b0;
            end
            else if (tog_flip_i)
            begin
                nxt_state.value[`UERX_BIT_TOG] =
                    ~state_ff.value[`UERX_BIT_TOG];
            end
            if (force_nak_i)
            begin
                nxt_state.value[`UERX_STAT_HI:`UERX_STAT_LO] = UERX_ST_NAK;
            end
        end
        if (IS_EP0)
        begin
            nxt_state.value[`UERX_BIT_CTRL] = 1'b1;
            nxt_state.value[`UERX_EPN_HI:`UERX_EPN_LO] = 4'h0;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_ff.value <= RST_VAL;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign reg_o = state_ff.value;

endmodule
`default_nettype wire

// ---- uerx_irq.sv ----
// Sticky event status with enable and write-one clear
`timescale 1ns/1ps
`default_nettype none
`include "uerx_params.svh"

module uerx_irq
#(
    parameter int W = `UERX_IRQ_W
)
(
    input  wire logic         MCLK_I,
    input  wire logic         ARST_N_I,
    input  wire logic [W-1:0] event_i,
    input  wire logic [W-1:0] clr_i,
    input  wire logic         en_wr_i,
    input  wire logic [W-1:0] en_data_i,
    output logic      [W-1:0] stat_o,
    output logic      [W-1:0] en_o,
    output logic              irq_o
);
    import uerx_pkg::*;

    typedef struct packed
    {
        logic [W-1:0] stat;
        logic [W-1:0] en;
    } uerx_irq_state_t;

    uerx_irq_state_t state_ff;
    uerx_irq_state_t nxt_state;

    always_comb
    begin
        nxt_state = state_ff;
        // Set beats clear so no event is lost
        nxt_state.stat = (state_ff.stat & ~clr_i) | event_i;
        if (en_wr_i)
        begin
            nxt_state.en = en_data_i;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign stat_o = state_ff.stat;
    assign en_o   = state_ff.en;
    assign irq_o  = |(state_ff.stat & state_ff.en);

endmodule
`default_nettype wire

// ---- uerx_top.sv ----
// USB endpoint receive control: registers, handshake choice, AXI slave
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "uerx_params.svh"

module uerx_top
#(
    parameter bit HAS_EP2 = 1'b1
)
(
    input  wire logic             MCLK_I,
    input  wire logic             ARST_N_I,
    // AXI4-Lite slave
    input  wire logic [11:0]      S_AXI_AWADDR_I,
    input  wire logic             S_AXI_AWVALID_I,
    output logic                  S_AXI_AWREADY_O,
    input  wire logic [31:0]      S_AXI_WDATA_I,
    input  wire logic [3:0]       S_AXI_WSTRB_I,
    input  wire logic             S_AXI_WVALID_I,
    output logic                  S_AXI_WREADY_O,
    output logic [1:0]            S_AXI_BRESP_O,
    output logic                  S_AXI_BVALID_O,
    input  wire logic             S_AXI_BREADY_I,
    input  wire logic [11:0]      S_AXI_ARADDR_I,
    input  wire logic             S_AXI_ARVALID_I,
    output logic                  S_AXI_ARREADY_O,
    output logic [31:0]           S_AXI_RDATA_O,
    output logic [1:0]            S_AXI_RRESP_O,
    output logic                  S_AXI_RVALID_O,
    input  wire logic             S_AXI_RREADY_I,
    // USB receive engine side (same clock)
    input  wire logic             USB_BUS_RST_I,
    input  wire logic             RX_TOKEN_I,
    input  wire uerx_pkg::uerx_tok_t RX_TOKEN_PID_I,
    input  wire logic [3:0]       RX_TOKEN_EPN_I,
    input  wire logic             RX_DATA_DONE_I,
    input  wire logic             RX_DATA_OK_I,
    input  wire logic             RX_DATA_PID_I,
    output uerx_pkg::uerx_hs_t    RX_HS_O,
    output logic                  RX_HS_VALID_O,
    output logic                  RX_IS_CTRL_O,
    output logic                  RX_TOG_EXP_O,
    output logic [1:0]            CORRECT_TRANSFER_FLAG_O,
    output logic                  IRQ_O
);
    import uerx_pkg::*;

    localparam int NEP = `UERX_NUM_EP;

    // -----------------------------------------------------------
    // State
    // -----------------------------------------------------------
    typedef struct packed
    {
        logic        aw_hold;
        logic [11:0] aw_addr;
        logic        w_hold;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        bus_rst_d;
        logic        tok_act;
        logic [1:0]  tok_ep;
        logic        tok_setup;
        uerx_hs_t    hs;
        logic        hs_valid;
        logic        is_ctrl;
        logic        tog_exp;
        logic [1:0]  ctr;
    } uerx_top_state_t;

    uerx_top_state_t state_ff;
    uerx_top_state_t nxt_state;

    logic [7:0]         ep_reg   [NEP];
    logic [NEP-1:0]     ep_wr;
    logic [NEP-1:0]     ep_setup_clr;
    logic [NEP-1:0]     ep_flip;
    logic [NEP-1:0]     ep_nak;
    logic [NEP-1:0]     ep_hit;
    logic [NEP-1:0]     ep_present;
    logic               bus_rst_pulse;
    logic [`UERX_IRQ_W-1:0] irq_event;
    logic [`UERX_IRQ_W-1:0] irq_clr;
    logic               irq_en_wr;
    logic [`UERX_IRQ_W-1:0] irq_stat;
    logic [`UERX_IRQ_W-1:0] irq_en;
    logic               wr_go;
    logic               rd_go;
    logic               wr_known;
    logic               sel_any;
    logic [1:0]         sel_ep;
    uerx_stat_t         sel_stat;
    logic               good_data;

    // -----------------------------------------------------------
    // Endpoint registers
    // -----------------------------------------------------------
    assign ep_present = {HAS_EP2, 2'b11};

    generate
        for (genvar i = 0; i < NEP; i++)
        begin : g_ep
            if (i == 2 && !HAS_EP2)
            begin : g_absent
                assign ep_reg[i] = 8'h00;
            end
            else
            begin : g_present
                uerx_epreg
                #(
                    .IS_EP0 (i == 0)
                )
                u_reg
                (
                    .MCLK_I      (MCLK_I),
                    .ARST_N_I    (ARST_N_I),
                    .bus_rst_i   (bus_rst_pulse),
                    .wr_i        (ep_wr[i]),
                    .wdata_i     (state_ff.w_data[7:0]),
                    .setup_clr_i (ep_setup_clr[i]),
                    .tog_flip_i  (ep_flip[i]),
                    .force_nak_i (ep_nak[i]),
                    .reg_o       (ep_reg[i])
                );
            end
            // Endpoint 0 matches only number zero
            assign ep_hit[i] = ep_present[i] &&
                (ep_reg[i][`UERX_EPN_HI:`UERX_EPN_LO] == RX_TOKEN_EPN_I);
        end
    endgenerate

    // -----------------------------------------------------------
    // Interrupt status
    // -----------------------------------------------------------
    uerx_irq
    #(
        .W (`UERX_IRQ_W)
    )
    u_irq
    (
        .MCLK_I    (MCLK_I),
        .ARST_N_I  (ARST_N_I),
        .event_i   (irq_event),
        .clr_i     (irq_clr),
        .en_wr_i   (irq_en_wr),
        .en_data_i (state_ff.w_data[`UERX_IRQ_W-1:0]),
        .stat_o    (irq_stat),
        .en_o      (irq_en),
        .irq_o     (IRQ_O)
    );

    // -----------------------------------------------------------
    // Transaction and bus logic
    // -----------------------------------------------------------
    always_comb
    begin
        nxt_state     = state_ff;
        ep_wr         = '0;
        ep_setup_clr  = '0;
        ep_flip       = '0;
        ep_nak        = '0;
        irq_event     = '0;
        irq_clr       = '0;
        irq_en_wr     = 1'b0;
        sel_any       = 1'b0;
        sel_ep        = 2'h0;
        good_data     = 1'b0;
        wr_known      = 1'b0;
        bus_rst_pulse = USB_BUS_RST_I & ~state_ff.bus_rst_d;
        nxt_state.bus_rst_d = USB_BUS_RST_I;
        nxt_state.hs_valid  = 1'b0;
        nxt_state.ctr       = 2'h0;

        // Lowest matching endpoint wins if software duplicates numbers
        for (int k = NEP - 1; k >= 0; k--)
        begin
            if (ep_hit[k])
            begin
                sel_any = 1'b1;
                sel_ep  = 2'(k);
            end
        end
        sel_stat = uerx_stat_t'(ep_reg[sel_ep][`UERX_STAT_HI:`UERX_STAT_LO]);

        if (RX_TOKEN_I)
        begin
            nxt_state.tok_act   = sel_any;
            nxt_state.tok_ep    = sel_ep;
            nxt_state.tok_setup = (RX_TOKEN_PID_I == UERX_PID_SETUP);
            nxt_state.is_ctrl   = (sel_ep == 2'h0) ||
                                  ep_reg[sel_ep][`UERX_BIT_CTRL];
            nxt_state.tog_exp   = ep_reg[sel_ep][`UERX_BIT_TOG];
            if (sel_any && RX_TOKEN_PID_I == UERX_PID_SETUP &&
                nxt_state.is_ctrl && sel_stat != UERX_ST_DISABLED)
            begin
                ep_setup_clr[sel_ep] = 1'b1;
                nxt_state.tog_exp    = 1'b0;
            end
        end
        else if (RX_DATA_DONE_I && state_ff.tok_act)
        begin
            nxt_state.tok_act  = 1'b0;
            nxt_state.hs_valid = 1'b1;
            sel_stat = uerx_stat_t'(
                ep_reg[state_ff.tok_ep][`UERX_STAT_HI:`UERX_STAT_LO]);
            // SETUP on a control endpoint is accepted unless the endpoint is disabled
            if (state_ff.tok_setup && state_ff.is_ctrl &&
                sel_stat != UERX_ST_DISABLED)
            begin
                sel_stat = UERX_ST_VALID;
            end
            good_data = RX_DATA_OK_I &&
                        (RX_DATA_PID_I == state_ff.tog_exp);
            unique case (sel_stat)
                UERX_ST_DISABLED:
                begin
                    nxt_state.hs_valid = 1'b0;
                    nxt_state.hs       = UERX_HS_NONE;
                end
                UERX_ST_STALL:
                begin
                    nxt_state.hs = UERX_HS_STALL;
                    irq_event[1] = 1'b1;
                end
                UERX_ST_NAK:
                begin
                    nxt_state.hs = UERX_HS_NAK;
                    irq_event[2] = 1'b1;
                end
                UERX_ST_VALID:
                begin
                    if (!RX_DATA_OK_I)
                    begin
                        nxt_state.hs_valid = 1'b0;
                        nxt_state.hs       = UERX_HS_NONE;
                        irq_event[3]       = 1'b1;
                    end
                    else
                    begin
                        nxt_state.hs = UERX_HS_ACK;
                        if (good_data)
                        begin
                            ep_flip[state_ff.tok_ep] = 1'b1;
                            ep_nak[state_ff.tok_ep]  = 1'b1;
                            nxt_state.ctr[0]   = 1'b1;
                            nxt_state.ctr[1]   = state_ff.tok_setup;
                            irq_event[0]       = 1'b1;
                        end
                    end
                end
            endcase
        end

        // AXI write channel, address and data in either order
        if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
        begin
            nxt_state.aw_hold = 1'b1;
            nxt_state.aw_addr = S_AXI_AWADDR_I;
        end
        if (S_AXI_WVALID_I && S_AXI_WREADY_O)
        begin
            nxt_state.w_hold = 1'b1;
            nxt_state.w_data = S_AXI_WDATA_I;
            nxt_state.w_strb = S_AXI_WSTRB_I;
        end
        wr_go = state_ff.aw_hold && state_ff.w_hold && !state_ff.bvalid;
        if (wr_go)
        begin
            nxt_state.aw_hold = 1'b0;
            nxt_state.w_hold  = 1'b0;
            nxt_state.bvalid  = 1'b1;
            unique case (state_ff.aw_addr)
                `UERX_OFF_EP0: wr_known = 1'b1;
                `UERX_OFF_EP1: wr_known = 1'b1;
                `UERX_OFF_EP2: wr_known = HAS_EP2;
                `UERX_OFF_IRQ_CLR: wr_known = 1'b1;
                `UERX_OFF_IRQ_EN: wr_known = 1'b1;
                default: wr_known = 1'b0;
            endcase
            nxt_state.bresp = wr_known ? 2'h0 : 2'h2;
            // Only byte lane 0 holds register bits
            if (state_ff.w_strb[0])
            begin
                ep_wr[0] = (state_ff.aw_addr == `UERX_OFF_EP0);
                ep_wr[1] = (state_ff.aw_addr == `UERX_OFF_EP1);
                ep_wr[2] = (state_ff.aw_addr == `UERX_OFF_EP2) && HAS_EP2;
                if (state_ff.aw_addr == `UERX_OFF_IRQ_CLR)
                begin
                    irq_clr = state_ff.w_data[`UERX_IRQ_W-1:0];
                end
                irq_en_wr = (state_ff.aw_addr == `UERX_OFF_IRQ_EN);
            end
        end
        if (state_ff.bvalid && S_AXI_BREADY_I)
        begin
            nxt_state.bvalid = 1'b0;
        end

        // AXI read channel
        rd_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
        if (rd_go)
        begin
            nxt_state.rvalid = 1'b1;
            nxt_state.rresp  = 2'h0;
            nxt_state.rdata  = 32'h0;
            unique case (S_AXI_ARADDR_I)
                `UERX_OFF_EP0: nxt_state.rdata[7:0] = ep_reg[0];
                `UERX_OFF_EP1: nxt_state.rdata[7:0] = ep_reg[1];
                `UERX_OFF_EP2:
                begin
                    nxt_state.rdata[7:0] = ep_reg[2];
                    nxt_state.rresp      = HAS_EP2 ? 2'h0 : 2'h2;
                end
                `UERX_OFF_IRQ_STAT:
                    nxt_state.rdata[`UERX_IRQ_W-1:0] = irq_stat;
                `UERX_OFF_IRQ_EN:
                    nxt_state.rdata[`UERX_IRQ_W-1:0] = irq_en;
                default: nxt_state.rresp = 2'h2;
            endcase
        end
        else if (state_ff.rvalid && S_AXI_RREADY_I)
        begin
            nxt_state.rvalid = 1'b0;
        end

        if (bus_rst_pulse)
        begin
            nxt_state.tok_act = 1'b0;
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            state_ff <= '0;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // -----------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------
    assign S_AXI_AWREADY_O         = !state_ff.aw_hold;
    assign S_AXI_WREADY_O          = !state_ff.w_hold;
    assign S_AXI_BVALID_O          = state_ff.bvalid;
    assign S_AXI_BRESP_O           = state_ff.bresp;
    assign S_AXI_ARREADY_O         = !state_ff.rvalid;
    assign S_AXI_RVALID_O          = state_ff.rvalid;
    assign S_AXI_RDATA_O           = state_ff.rdata;
    assign S_AXI_RRESP_O           = state_ff.rresp;
    assign RX_HS_O                 = state_ff.hs;
    assign RX_HS_VALID_O           = state_ff.hs_valid;
    assign RX_IS_CTRL_O            = state_ff.is_ctrl;
    assign RX_TOG_EXP_O            = state_ff.tog_exp;
    assign CORRECT_TRANSFER_FLAG_O = state_ff.ctr;

endmodule
`default_nettype wire

// ---- uerx_properties.sv ----
// Concurrent checks on the endpoint receive ports
`timescale 1ns/1ps
`default_nettype none
module uerx_chk
(
    input wire logic                MCLK_I,
    input wire logic                ARST_N_I,
    input wire logic                RX_TOKEN_I,
    input wire logic [3:0]          RX_TOKEN_EPN_I,
    input wire logic                RX_DATA_DONE_I,
    input wire logic                RX_DATA_OK_I,
    input wire uerx_pkg::uerx_hs_t  RX_HS_O,
    input wire logic                RX_HS_VALID_O,
    input wire logic                RX_IS_CTRL_O,
    input wire logic [1:0]          CORRECT_TRANSFER_FLAG_O
);
    import uerx_pkg::*;
    // ---------------------------------------------------------------
    // Handshake and transfer flag relations
    // ---------------------------------------------------------------
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (!ARST_N_I);

    a_hs_after_done: assert property (
        RX_HS_VALID_O |-> $past(RX_DATA_DONE_I))
        else $error("handshake without packet end");
    a_hs_one_cycle: assert property (
        RX_HS_VALID_O |=> !RX_HS_VALID_O)
        else $error("handshake longer than one cycle");
    a_ctr_is_ack: assert property (
        CORRECT_TRANSFER_FLAG_O[0] |-> RX_HS_VALID_O
        && RX_HS_O == UERX_HS_ACK)
        else $error("correct transfer without ACK");
    a_ctr_needs_ok: assert property (
        CORRECT_TRANSFER_FLAG_O[0] |-> $past(RX_DATA_OK_I))
        else $error("correct transfer after bad packet");
    a_bad_no_ctr: assert property (
        RX_DATA_DONE_I && !RX_DATA_OK_I |=> CORRECT_TRANSFER_FLAG_O == 2'h0)
        else $error("bad packet flagged correct");
    a_setup_flag: assert property (
        CORRECT_TRANSFER_FLAG_O[1] |-> CORRECT_TRANSFER_FLAG_O[0])
        else $error("setup flag without transfer flag");
    a_refuse_no_ctr: assert property (
        RX_HS_VALID_O && RX_HS_O != UERX_HS_ACK
        |-> !CORRECT_TRANSFER_FLAG_O[0])
        else $error("refused packet flagged correct");
    a_ep0_ctrl: assert property (
        RX_TOKEN_I && RX_TOKEN_EPN_I == 4'h0 |=> RX_IS_CTRL_O)
        else $error("endpoint zero not control");

    c_setup: cover property (CORRECT_TRANSFER_FLAG_O == 2'h3);
    c_stall: cover property (RX_HS_VALID_O && RX_HS_O == UERX_HS_STALL);
    c_nak: cover property (RX_HS_VALID_O && RX_HS_O == UERX_HS_NAK);
endmodule
`default_nettype wire

// ---- uerx_host.sv ----
// USB host model: tokens and data packets
`timescale 1ns/1ps
`default_nettype none
module uerx_host
(
    input  wire logic                MCLK_I,
    input  wire uerx_pkg::uerx_hs_t  hs_i,
    input  wire logic                hs_valid_i,
    input  wire logic [1:0]          ctr_i,
    output logic                     bus_rst_o,
    output logic                     tok_o,
    output uerx_pkg::uerx_tok_t      pid_o,
    output logic [3:0]               epn_o,
    output logic                     done_o,
    output logic                     ok_o,
    output logic                     dpid_o
);
    import uerx_pkg::*;
    logic idle = 1'b1;
    initial
    begin
        {bus_rst_o, tok_o, done_o, ok_o, dpid_o} = 5'h0;
        {pid_o, epn_o} = {UERX_PID_OUT, 4'h0};
    end
    // Churn idle qualifiers so stale values never match
    always @(posedge MCLK_I)
        if (idle)
        begin
            {epn_o, ok_o, dpid_o} <= ~{epn_o, ok_o, dpid_o};
        end
    task automatic xfer(input uerx_tok_t p, input logic [3:0] e,
                        input logic d, k, output uerx_hs_t h,
                        output logic [1:0] c);
        h = UERX_HS_NONE;
        c = 2'h0;
        idle = 1'b0;
        @(posedge MCLK_I);
        {tok_o, pid_o, epn_o} <= {1'b1, p, e};
        @(posedge MCLK_I);
        {tok_o, done_o, ok_o, dpid_o} <= {1'b0, 1'b1, k, d};
        @(posedge MCLK_I);
        done_o <= 1'b0;
        repeat (4)
        begin
            @(negedge MCLK_I);
            if (hs_valid_i === 1'b1)
                {h, c} = {hs_i, ctr_i};
        end
        idle = 1'b1;
    endtask
    task automatic bus_reset();
        @(posedge MCLK_I);
        bus_rst_o <= 1'b1;
        repeat (2) @(posedge MCLK_I);
        bus_rst_o <= 1'b0;
        @(posedge MCLK_I);
    endtask
endmodule
`default_nettype wire

// ---- usb_endpoint_rx_control_test.sv ----
// Register and packet test of the endpoint receive control
`timescale 1ns/1ps
`default_nettype none
`include "uerx_params.svh"
module usb_endpoint_rx_control_test;
    import uerx_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus state and helpers
    // ---------------------------------------------------------------
    logic        clk = 1'b0, arst_n = 1'b0;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, r, ctr, c;
    logic        bus_rst, tok, done, ok, dpid, hs_v, is_ctrl, tog_exp, irq;
    logic [3:0]  epn;
    uerx_tok_t   pid;
    uerx_hs_t    hs, h;
    uerx_hs_t    tbl [3] = '{UERX_HS_NONE, UERX_HS_STALL, UERX_HS_NAK};
    int          failures = 0, samples_checked = 0;

    always #10 clk = ~clk;

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // A valid drops only after the edge that takes it
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic ta, tw, fin;
        fin = 0;
        @(posedge clk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'h7};
        for (int n = 0; n < 20 && !fin; n++)
        begin
            @(negedge clk);
            {ta, tw} = {awvalid & awready, wvalid & wready};
            fin = bready & bvalid;
            @(posedge clk);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
            if (fin) bready <= 0;
        end
        if (!fin) begin failures++; end_sim(); end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v,
                      output logic [1:0] rs);
        logic ta, fin;
        fin = 0;
        @(posedge clk);
        {araddr, arvalid, rready} <= {a, 2'h3};
        for (int n = 0; n < 20 && !fin; n++)
        begin
            @(negedge clk);
            {ta, fin, v, rs} = {arvalid & arready, rvalid, rdata, rresp};
            @(posedge clk);
            if (ta) arvalid <= 0;
            if (fin) rready <= 0;
        end
        if (!fin) begin failures++; end_sim(); end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        rd(a, d, r);
        chk(d, e);
    endtask
    task automatic usb(input uerx_tok_t p, input logic [3:0] e,
                       input logic dp, k, input uerx_hs_t eh);
        uerx_host_inst.xfer(p, e, dp, k, h, c);
        chk({30'h0, h}, {30'h0, eh});
    endtask

    uerx_top #(.HAS_EP2(1'b1)) uerx_top_inst (
        .MCLK_I(clk), .ARST_N_I(arst_n),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
        .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp),
        .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
        .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata),
        .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
        .S_AXI_RREADY_I(rready), .USB_BUS_RST_I(bus_rst),
        .RX_TOKEN_I(tok), .RX_TOKEN_PID_I(pid), .RX_TOKEN_EPN_I(epn),
        .RX_DATA_DONE_I(done), .RX_DATA_OK_I(ok), .RX_DATA_PID_I(dpid),
        .RX_HS_O(hs), .RX_HS_VALID_O(hs_v), .RX_IS_CTRL_O(is_ctrl),
        .RX_TOG_EXP_O(tog_exp), .CORRECT_TRANSFER_FLAG_O(ctr),
        .IRQ_O(irq));
    uerx_host uerx_host_inst (
        .MCLK_I(clk), .hs_i(hs), .hs_valid_i(hs_v), .ctr_i(ctr),
        .bus_rst_o(bus_rst), .tok_o(tok), .pid_o(pid), .epn_o(epn),
        .done_o(done), .ok_o(ok), .dpid_o(dpid));

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rchk(`UERX_OFF_EP0, 32'h80);
        rchk(`UERX_OFF_EP1, 32'h00);
        rchk(`UERX_OFF_EP2, 32'h00);
        wr(`UERX_OFF_EP0, 32'hff);
        rchk(`UERX_OFF_EP0, 32'hf0);
        wr(`UERX_OFF_IRQ_EN, 32'h1);
        wr(`UERX_OFF_EP1, 32'hb1);
        usb(UERX_PID_OUT, 4'h1, 1'b0, 1'b1, UERX_HS_ACK);
        chk({30'h0, c}, 32'h1);
        chk({31'h0, is_ctrl}, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rchk(`UERX_OFF_EP1, 32'he1);
        wr(`UERX_OFF_IRQ_CLR, 32'h1);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0);
        wr(`UERX_OFF_EP1, 32'h71);
        usb(UERX_PID_OUT, 4'h1, 1'b0, 1'b1, UERX_HS_ACK);
        chk({31'h0, is_ctrl}, 32'h0);
        rchk(`UERX_OFF_EP1, 32'h71);
        usb(UERX_PID_OUT, 4'h1, 1'b1, 1'b0, UERX_HS_NONE);
        rchk(`UERX_OFF_EP1, 32'h71);
        for (int s = 0; s < 3; s++)
        begin
            wr(`UERX_OFF_EP1, {26'h0, 2'(s), 4'h1});
            usb(UERX_PID_OUT, 4'h1, 1'b0, 1'b1, tbl[s]);
            rchk(`UERX_OFF_EP1, {26'h0, 2'(s), 4'h1});
        end
        wr(`UERX_OFF_EP2, 32'h32);
        usb(UERX_PID_OUT, 4'h5, 1'b0, 1'b1, UERX_HS_NONE);
        rchk(`UERX_OFF_EP2, 32'h32);
        usb(UERX_PID_OUT, 4'h2, 1'b0, 1'b1, UERX_HS_ACK);
        usb(UERX_PID_SETUP, 4'h0, 1'b0, 1'b1, UERX_HS_ACK);
        chk({30'h0, c}, 32'h3);
        chk({31'h0, tog_exp}, 32'h0);
        rchk(`UERX_OFF_EP0, 32'he0);
        uerx_host_inst.bus_reset();
        rchk(`UERX_OFF_EP0, 32'h80);
        rchk(`UERX_OFF_EP1, 32'h00);
        rd(12'h020, d, r);
        chk({30'h0, r}, 32'h2);
        end_sim();
    end
endmodule

bind uerx_top uerx_chk uerx_chk_inst (
    .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .RX_TOKEN_I(RX_TOKEN_I),
    .RX_TOKEN_EPN_I(RX_TOKEN_EPN_I), .RX_DATA_DONE_I(RX_DATA_DONE_I),
    .RX_DATA_OK_I(RX_DATA_OK_I), .RX_HS_O(RX_HS_O),
    .RX_HS_VALID_O(RX_HS_VALID_O), .RX_IS_CTRL_O(RX_IS_CTRL_O),
    .CORRECT_TRANSFER_FLAG_O(CORRECT_TRANSFER_FLAG_O));
`default_nettype wire
